// >>> src/apk_ctrl.sv
/*
 * Result registers, peak tracking, display source and hold, negative display
 * formatting, supply-low flag, offset calibration and power-down control.
 * Assumes control bits and conversion results come from same-clock logic; the
 * supply monitor comparator output is asynchronous and is synchronised here.
 */
// Contract
// RULE1: peak register is 16-bit read-only, resets to zero, loaded only by tracking.
// RULE2: enabling peak tracking first copies present conversion result into peak register.
// RULE3: while tracking, a new result replaces the peak only when larger.
// RULE4: clearing the peak enable clears the peak register.
// RULE5: tracking is valid only within the documented reading range per variant.
// RULE6: peak held in two's complement; short variant keeps 12 bits above four sub-bits.
// RULE7: low result register is 8-bit, upper nibble result bits, lower nibble zero.
// RULE8: host joins high sixteen bits and low four bits into a 20-bit value.
// RULE9: reset returns every register and control path to its default.
// RULE10: offset calibration runs on every conversion while auto control bit is zero.
// RULE11: writing one to the enhanced trigger starts an enhanced offset calibration.
// RULE12: digital and analog power-down bits act independently.
// RULE13: digital power-down stops filter and display; analog stops modulator and buffers.
// RULE14: with peak tracking on, the display shows only the highest value.
// RULE15: with hold on, the display keeps the reading present at activation.
// RULE16: supply monitor below threshold sets supply-low flag and low-battery segment; code sets the segment only while digital power-down is off.
// RULE17: negative results display magnitude minus one with a minus sign.
// RULE18: display register loads from high result, peak, or serial writes by selection.
// RULE19: high result register holds the sixteen upper result bits, read-only.
// RULE20: peak comparison is signed so a less negative reading counts larger.
`timescale 1ns/1ns
`default_nettype none
module apk_ctrl
	import apk_pkg::*;
#(
	parameter bit FOUR_HALF = 1'b1,
	parameter int CONV_W = RES_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// control bits from the register file
	input wire apk_ctrl_t ctrl,
	input wire logic enhanced_offset_trigger,
	input wire logic disp_wr,
	input wire logic [HIGH_W-1:0] disp_wdata,
	// digital filter side
	input wire logic conv_valid,
	input wire logic [CONV_W-1:0] conv_result,
	input wire logic cal_done,
	// supply monitor comparator, high while below threshold
	input wire logic supply_monitor_input,
	// readable registers
	output logic [HIGH_W-1:0] result_high_q,
	output logic [LOW_W-1:0] conversion_result_low_q,
	output logic [HIGH_W-1:0] peak_capture_q,
	output logic [HIGH_W-1:0] display_data_q,
	output logic supply_low_flag_q,
	output logic cal_busy_q,
	// analog and display control
	output apk_pwr_t pwr_q,
	output logic offset_cal_every_conv_q,
	output logic enhanced_cal_start_q,
	output apk_disp_t disp_q
);

	if (CONV_W != RES_W) begin : g_width_check
		$error("apk_ctrl: conversion width must be 20");
	end

	// short variant ignores the four trailing sub-bits
	function automatic logic [HIGH_W-1:0] trim(input logic [HIGH_W-1:0] v);
		trim = FOUR_HALF ? v : (v & SUB_MASK); // RULE6
	endfunction : trim

	logic peak_en_q;
	logic supply_low_s;
	logic conv_take;
	logic peak_start;
	logic peak_bigger;
	logic [HIGH_W-1:0] new_high;
	logic [HIGH_W-1:0] disp_val;

	assign new_high = trim(conv_result[CONV_W-1 -: HIGH_W]);
	// no new results while the filter or modulator is powered down
	assign conv_take = conv_valid && !ctrl.digital_powerdown && !ctrl.analog_powerdown; // RULE13
	assign peak_start = ctrl.peak_en && !peak_en_q; // RULE2
	// results outside the valid reading range are not guarded against
	assign peak_bigger = $signed(new_high) > $signed(peak_capture_q); // RULE20 RULE5
	assign disp_val = FOUR_HALF ? display_data_q : HIGH_W'($signed(display_data_q) >>> SUB_BITS);

	apk_sync2 u_supply_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in(supply_monitor_input),
		.sync_out(supply_low_s)
	);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			result_high_q <= RESULT_HIGH_RST; // RULE9
			conversion_result_low_q <= RESULT_LOW_RST;
		end else if (conv_take) begin
			result_high_q <= new_high; // RULE19
			conversion_result_low_q <= {conv_result[SUB_BITS-1:0], LOW_PAD}; // RULE7
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			peak_en_q <= 1'b0;
		end else begin
			peak_en_q <= ctrl.peak_en;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			peak_capture_q <= PEAK_RST; // RULE1
		end else if (!ctrl.peak_en) begin
			peak_capture_q <= PEAK_RST; // RULE4
		end else if (peak_start) begin
			peak_capture_q <= result_high_q; // RULE2
		end else if (conv_take && peak_bigger) begin
			peak_capture_q <= new_high; // RULE3
		end
	end

	// hold outranks peak, peak outranks serial and result sources
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			display_data_q <= DISPLAY_RST;
		end else if (ctrl.hold_en) begin
			display_data_q <= display_data_q; // RULE15
		end else if (ctrl.peak_en) begin
			display_data_q <= peak_capture_q; // RULE14 RULE18
		end else if (ctrl.serial_src) begin
			if (disp_wr) begin
				display_data_q <= disp_wdata; // RULE18
			end
		end else begin
			display_data_q <= result_high_q; // RULE18
		end
	end

	// one's complement of a negative value is magnitude minus one
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			disp_q <= '0;
		end else begin
			disp_q.minus_sign <= disp_val[HIGH_W-1]; // RULE17
			disp_q.magnitude <= disp_val[HIGH_W-1] ? ~disp_val : disp_val; // RULE17
			disp_q.supply_monitor_input_seg <= supply_low_s && !ctrl.digital_powerdown; // RULE16
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			supply_low_flag_q <= 1'b0;
		end else begin
			supply_low_flag_q <= supply_low_s; // RULE16
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pwr_q <= '0;
		end else begin
			pwr_q.filter_en <= !ctrl.digital_powerdown; // RULE12 RULE13
			pwr_q.display_drv_en <= !ctrl.digital_powerdown; // RULE13
			pwr_q.modulator_en <= !ctrl.analog_powerdown; // RULE12 RULE13
			pwr_q.input_buf_en <= !ctrl.analog_powerdown; // RULE13
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			offset_cal_every_conv_q <= 1'b0;
		end else begin
			offset_cal_every_conv_q <= !ctrl.auto_offset_control; // RULE10
		end
	end

	// a trigger landing on the done cycle restarts rather than being lost
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cal_busy_q <= 1'b0;
			enhanced_cal_start_q <= 1'b0;
		end else begin
			enhanced_cal_start_q <= enhanced_offset_trigger; // RULE11
			if (enhanced_offset_trigger) begin
				cal_busy_q <= 1'b1; // RULE11
			end else if (cal_done) begin
				cal_busy_q <= 1'b0;
			end
		end
	end

	property p_peak_clear;
		@(posedge ref_clk) disable iff (sys_rst)
		!ctrl.peak_en |=> peak_capture_q == PEAK_RST;
	endproperty
	a_peak_clear: assert property (p_peak_clear) else $error("peak not cleared"); // RULE4

	property p_peak_start;
		@(posedge ref_clk) disable iff (sys_rst)
		peak_start |=> peak_capture_q == $past(result_high_q);
	endproperty
	a_peak_start: assert property (p_peak_start) else $error("peak start copy wrong"); // RULE2

	property p_peak_mono;
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.peak_en && peak_en_q) ##1 ctrl.peak_en
			|-> $signed(peak_capture_q) >= $signed($past(peak_capture_q));
	endproperty
	a_peak_mono: assert property (p_peak_mono) else $error("peak decreased"); // RULE3

	property p_peak_update;
		@(posedge ref_clk) disable iff (sys_rst)
		(peak_en_q && ctrl.peak_en && conv_take && peak_bigger) ##1 ctrl.peak_en
			|-> peak_capture_q == $past(new_high);
	endproperty
	a_peak_update: assert property (p_peak_update) else $error("peak not updated"); // RULE3

	property p_low_nibble;
		@(posedge ref_clk) disable iff (sys_rst)
		conv_take |=> conversion_result_low_q == {$past(conv_result[3:0]), 4'h0};
	endproperty
	a_low_nibble: assert property (p_low_nibble) else $error("low result wrong"); // RULE7

	property p_high_load;
		@(posedge ref_clk) disable iff (sys_rst)
		conv_take |=> result_high_q == trim($past(conv_result[19:4]));
	endproperty
	a_high_load: assert property (p_high_load) else $error("high result wrong"); // RULE19

	property p_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		ctrl.hold_en |=> $stable(display_data_q);
	endproperty
	a_hold: assert property (p_hold) else $error("display moved under hold"); // RULE15

	property p_peak_display;
		@(posedge ref_clk) disable iff (sys_rst)
		(!ctrl.hold_en && ctrl.peak_en) |=> display_data_q == $past(peak_capture_q);
	endproperty
	a_peak_display: assert property (p_peak_display) else $error("peak not shown"); // RULE14

	property p_negative;
		@(posedge ref_clk) disable iff (sys_rst)
		disp_val[15] |=> disp_q.minus_sign && disp_q.magnitude == ~$past(disp_val);
	endproperty
	a_negative: assert property (p_negative) else $error("negative display wrong"); // RULE17

	property p_supply;
		@(posedge ref_clk) disable iff (sys_rst)
		supply_low_s |=> supply_low_flag_q;
	endproperty
	a_supply: assert property (p_supply) else $error("supply-low flag missing"); // RULE16

	property p_powerdown;
		@(posedge ref_clk) disable iff (sys_rst)
		ctrl.digital_powerdown && !ctrl.analog_powerdown
			|=> !pwr_q.display_drv_en && !pwr_q.filter_en && pwr_q.modulator_en;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("power-down wrong"); // RULE13

	property p_cal;
		@(posedge ref_clk) disable iff (sys_rst)
		enhanced_offset_trigger |=> enhanced_cal_start_q && cal_busy_q;
	endproperty
	a_cal: assert property (p_cal) else $error("calibration not started"); // RULE11

	// not disabled by reset: this one guards the reset values themselves
	property p_reset_regs;
		@(posedge ref_clk)
		sys_rst |=> result_high_q == RESULT_HIGH_RST
			&& conversion_result_low_q == RESULT_LOW_RST && peak_capture_q == PEAK_RST
			&& display_data_q == DISPLAY_RST && !cal_busy_q;
	endproperty
	a_reset_regs: assert property (p_reset_regs) else $error("register not at default"); // RULE9

	property p_peak_idle;
		@(posedge ref_clk) disable iff (sys_rst)
		ctrl.peak_en && peak_en_q && !conv_take |=> $stable(peak_capture_q);
	endproperty
	a_peak_idle: assert property (p_peak_idle) else $error("peak moved without result"); // RULE1

	property p_peak_keep;
		@(posedge ref_clk) disable iff (sys_rst)
		ctrl.peak_en && peak_en_q && conv_take && !peak_bigger
			|=> $stable(peak_capture_q);
	endproperty
	a_peak_keep: assert property (p_peak_keep) else $error("smaller result replaced peak"); // RULE3

	property p_peak_signed;
		@(posedge ref_clk) disable iff (sys_rst)
		ctrl.peak_en && peak_en_q && conv_take && peak_capture_q[HIGH_W-1] && !new_high[HIGH_W-1]
			|=> !peak_capture_q[HIGH_W-1];
	endproperty
	a_peak_signed: assert property (p_peak_signed) else $error("signed peak compare wrong"); // RULE20

	property p_offset_auto;
		@(posedge ref_clk) disable iff (sys_rst)
		!ctrl.auto_offset_control |=> offset_cal_every_conv_q;
	endproperty
	a_offset_auto: assert property (p_offset_auto) else $error("auto offset cal off"); // RULE10

	property p_refuse_pd;
		@(posedge ref_clk) disable iff (sys_rst)
		conv_valid && (ctrl.digital_powerdown || ctrl.analog_powerdown)
			|=> $stable(result_high_q) && $stable(conversion_result_low_q);
	endproperty
	a_refuse_pd: assert property (p_refuse_pd) else $error("result taken in power-down"); // RULE13

	property p_analog_only;
		@(posedge ref_clk) disable iff (sys_rst)
		ctrl.analog_powerdown && !ctrl.digital_powerdown
			|=> pwr_q.filter_en && pwr_q.display_drv_en && !pwr_q.modulator_en && !pwr_q.input_buf_en;
	endproperty
	a_analog_only: assert property (p_analog_only) else $error("analog power-down wrong"); // RULE12

	property p_serial_write;
		@(posedge ref_clk) disable iff (sys_rst)
		!ctrl.hold_en && !ctrl.peak_en && ctrl.serial_src && disp_wr
			|=> display_data_q == $past(disp_wdata);
	endproperty
	a_serial_write: assert property (p_serial_write) else $error("serial write lost"); // RULE18

	property p_result_display;
		@(posedge ref_clk) disable iff (sys_rst)
		!ctrl.hold_en && !ctrl.peak_en && !ctrl.serial_src
			|=> display_data_q == $past(result_high_q);
	endproperty
	a_result_display: assert property (p_result_display) else $error("result not shown"); // RULE18

	property p_positive;
		@(posedge ref_clk) disable iff (sys_rst)
		!disp_val[HIGH_W-1]
			|=> !disp_q.minus_sign && disp_q.magnitude == $past(disp_val);
	endproperty
	a_positive: assert property (p_positive) else $error("positive display wrong"); // RULE17

	property p_low_seg;
		@(posedge ref_clk) disable iff (sys_rst)
		supply_low_s && !ctrl.digital_powerdown |=> disp_q.supply_monitor_input_seg;
	endproperty
	a_low_seg: assert property (p_low_seg) else $error("low-battery segment missing"); // RULE16

	property p_cal_end;
		@(posedge ref_clk) disable iff (sys_rst)
		cal_done && !enhanced_offset_trigger |=> !cal_busy_q;
	endproperty
	a_cal_end: assert property (p_cal_end) else $error("calibration busy after done"); // RULE11

	property p_cal_pulse;
		@(posedge ref_clk) disable iff (sys_rst)
		!enhanced_offset_trigger |=> !enhanced_cal_start_q;
	endproperty
	a_cal_pulse: assert property (p_cal_pulse) else $error("calibration start too long"); // RULE11

endmodule : apk_ctrl
`default_nettype wire

// >>> src/apk_pkg.sv
/*
 * Shared constants and carrier types for the converter result, peak-hold and
 * power/calibration control logic.
 * Assumes a single 250 MHz clock domain and a synchronous active-high reset.
 */
package apk_pkg;

	localparam int RES_W = 20;
	localparam int HIGH_W = 16;
	localparam int LOW_W = 8;
	localparam int SUB_BITS = 4;

	localparam logic [HIGH_W-1:0] PEAK_RST = 16'h0000;
	localparam logic [HIGH_W-1:0] RESULT_HIGH_RST = 16'h0000;
	localparam logic [HIGH_W-1:0] DISPLAY_RST = 16'h0000;
	localparam logic [LOW_W-1:0] RESULT_LOW_RST = 8'h00;
	localparam logic [SUB_BITS-1:0] LOW_PAD = 4'h0;
	localparam logic [HIGH_W-1:0] SUB_MASK = 16'hfff0;

	// control bits as delivered by the serial register file
	typedef struct packed {
		logic peak_en;
		logic hold_en;
		logic serial_src;
		logic auto_offset_control;
		logic digital_powerdown;
		logic analog_powerdown;
		logic range_sel;
	} apk_ctrl_t;

	// enables toward the filter, display and analog front end
	typedef struct packed {
		logic filter_en;
		logic display_drv_en;
		logic modulator_en;
		logic input_buf_en;
	} apk_pwr_t;

	// display drive word
	typedef struct packed {
		logic minus_sign;
		logic supply_monitor_input_seg;
		logic [HIGH_W-1:0] magnitude;
	} apk_disp_t;

endpackage : apk_pkg

// >>> src/apk_sync2.sv
/*
 * Two-flop level synchroniser.
 * Assumes the input is a slow level from outside the clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
module apk_sync2 (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);

	logic meta_q;
	logic sync_q;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : apk_sync2
`default_nettype wire

// >>> sim/apk_host.sv
/*
 * Host and filter-side model for apk_ctrl: control bits, pulses, results.
 * Assumes one bench process calls its tasks, all timed on ref_clk falls.
 */
`timescale 1ns/1ns
`default_nettype none
module apk_host
	import apk_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// control toward the block
	output var apk_ctrl_t ctrl,
	output logic trig,
	output logic disp_wr,
	output logic [HIGH_W-1:0] disp_wdata,
	// filter and supply side
	output logic conv_valid,
	output logic [RES_W-1:0] conv_result,
	output logic cal_done,
	output logic sup_in
);
	initial begin
		ctrl = '0;
		{trig, disp_wr, disp_wdata, conv_valid, conv_result, cal_done, sup_in} = '0;
	end
	task automatic set_ctrl(input apk_ctrl_t c);
		@(negedge ref_clk);
		ctrl <= c;
	endtask : set_ctrl
	task automatic conv(input logic [RES_W-1:0] v);
		@(negedge ref_clk);
		conv_valid <= 1'h1;
		conv_result <= v;
		@(negedge ref_clk);
		conv_valid <= 1'h0;
		// released bus never keeps the old word
		conv_result <= ~v;
	endtask : conv
	task automatic pulse_trig;
		@(negedge ref_clk);
		trig <= 1'h1;
		@(negedge ref_clk);
		trig <= 1'h0;
	endtask : pulse_trig
	task automatic pulse_done;
		@(negedge ref_clk);
		cal_done <= 1'h1;
		@(negedge ref_clk);
		cal_done <= 1'h0;
	endtask : pulse_done
	task automatic drive_supply(input logic b);
		@(negedge ref_clk);
		sup_in <= b;
	endtask : drive_supply
	task automatic write_disp(input logic [HIGH_W-1:0] d);
		@(negedge ref_clk);
		disp_wr <= 1'h1;
		disp_wdata <= d;
		@(negedge ref_clk);
		disp_wr <= 1'h0;
		disp_wdata <= ~d;
	endtask : write_disp
	function automatic logic [RES_W-1:0] join20(input logic [HIGH_W-1:0] hi,
		input logic [LOW_W-1:0] lo);
		return {hi, lo[7:4]};
	endfunction : join20
endmodule : apk_host
`default_nettype wire

// >>> sim/tb_top.sv
/*
 * Self-checking bench for apk_ctrl, one task per scenario.
 * Assumes the host model drives every input except ref_clk and sys_rst, which the bench drives; 4.5-digit variant.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import apk_pkg::*;
;
	logic ref_clk, sys_rst, trig, disp_wr, conv_valid, cal_done, sup_in;
	logic low_flag, cal_busy, every_conv, cal_start;
	logic [HIGH_W-1:0] disp_wdata, res_hi, peak, disp_data;
	logic [RES_W-1:0] conv_result;
	logic [LOW_W-1:0] res_lo;
	apk_ctrl_t ctrl;
	apk_pwr_t pwr;
	apk_disp_t disp;
	int miscompares, checks_done;

	apk_host apk_host_i (.ref_clk(ref_clk), .ctrl(ctrl), .trig(trig), .disp_wr(disp_wr),
		.disp_wdata(disp_wdata), .conv_valid(conv_valid), .conv_result(conv_result),
		.cal_done(cal_done), .sup_in(sup_in));
	apk_ctrl apk_ctrl_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .ctrl(ctrl),
		.enhanced_offset_trigger(trig), .disp_wr(disp_wr), .disp_wdata(disp_wdata),
		.conv_valid(conv_valid), .conv_result(conv_result), .cal_done(cal_done),
		.supply_monitor_input(sup_in), .result_high_q(res_hi),
		.conversion_result_low_q(res_lo), .peak_capture_q(peak),
		.display_data_q(disp_data), .supply_low_flag_q(low_flag), .cal_busy_q(cal_busy),
		.pwr_q(pwr), .offset_cal_every_conv_q(every_conv),
		.enhanced_cal_start_q(cal_start), .disp_q(disp));

	always #2 ref_clk = ~ref_clk;

	task automatic chk(input string nm, input logic [RES_W-1:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : idle
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic t_reset;
		chk("peak", 20'(peak), 20'h0);
		chk("lo", 20'(res_lo), 20'h0);
		chk("hi", 20'(res_hi), 20'h0);
		chk("disp", 20'(disp_data), 20'h0);
		chk("auto cal", 20'(every_conv), 20'h1);
	endtask : t_reset
	task automatic t_result;
		apk_host_i.conv(20'h12345);
		idle(1);
		chk("hi", 20'(res_hi), 20'h01234);
		chk("lo", 20'(res_lo), 20'h00050);
		chk("join", apk_host_i.join20(res_hi, res_lo), 20'h12345);
	endtask : t_result
	task automatic t_negative;
		logic [HIGH_W-1:0] hv [3] = '{16'hff9c, 16'hffff, 16'h0005};
		logic [HIGH_W-1:0] mv [3] = '{16'h0063, 16'h0000, 16'h0005};
		for (int i = 0; i < 3; i++) begin
			apk_host_i.conv({hv[i], 4'h7});
			idle(3);
			chk("sign", 20'(disp.minus_sign), 20'(hv[i][15]));
			chk("mag", 20'(disp.magnitude), 20'(mv[i]));
		end
	endtask : t_negative
	task automatic t_peak;
		apk_ctrl_t c = '0;
		apk_host_i.conv(20'hfffb0);
		c.peak_en = 1'h1;
		apk_host_i.set_ctrl(c);
		idle(2);
		chk("pk start", 20'(peak), 20'h0fffb);
		apk_host_i.conv(20'hfffe0);
		idle(1);
		chk("pk rise", 20'(peak), 20'h0fffe);
		apk_host_i.conv(20'hfed40);
		idle(2);
		chk("pk keep", 20'(peak), 20'h0fffe);
		chk("pk shown", 20'(disp_data), 20'h0fffe);
		apk_host_i.conv(20'h00120);
		idle(1);
		chk("pk signed", 20'(peak), 20'h00012);
		apk_host_i.set_ctrl('0);
		idle(2);
		chk("pk clear", 20'(peak), 20'h0);
	endtask : t_peak
	task automatic t_hold;
		apk_ctrl_t c = '0;
		apk_host_i.conv(20'h00100);
		idle(3);
		c.hold_en = 1'h1;
		apk_host_i.set_ctrl(c);
		apk_host_i.conv(20'h00200);
		apk_host_i.write_disp(16'h0bad);
		idle(3);
		chk("held", 20'(disp_data), 20'h00010);
		c = '0;
		c.serial_src = 1'h1;
		apk_host_i.set_ctrl(c);
		apk_host_i.write_disp(16'h0abc);
		idle(3);
		chk("serial", 20'(disp_data), 20'h00abc);
		apk_host_i.set_ctrl('0);
		apk_host_i.conv(20'h00300);
		idle(3);
		chk("result", 20'(disp_data), 20'h00030);
	endtask : t_hold
	task automatic t_power;
		apk_ctrl_t c = '0;
		c.digital_powerdown = 1'h1;
		apk_host_i.set_ctrl(c);
		apk_host_i.conv(20'h77770);
		idle(2);
		chk("pwr dig", 20'(pwr), 20'h3);
		chk("refused", 20'(res_hi), 20'h00030);
		c = '0;
		c.analog_powerdown = 1'h1;
		apk_host_i.set_ctrl(c);
		idle(2);
		chk("pwr ana", 20'(pwr), 20'hc);
		apk_host_i.set_ctrl('0);
		idle(2);
		chk("pwr on", 20'(pwr), 20'hf);
	endtask : t_power
	task automatic t_cal;
		apk_ctrl_t c = '0;
		c.auto_offset_control = 1'h1;
		c.range_sel = 1'h1;
		apk_host_i.set_ctrl(c);
		idle(2);
		chk("auto off", 20'(every_conv), 20'h0);
		apk_host_i.pulse_trig;
		chk("cal go", 20'({cal_start, cal_busy}), 20'h3);
		idle(1);
		chk("cal run", 20'({cal_start, cal_busy}), 20'h1);
		apk_host_i.pulse_done;
		chk("cal end", 20'(cal_busy), 20'h0);
		apk_host_i.set_ctrl('0);
	endtask : t_cal
	task automatic t_supply;
		apk_host_i.drive_supply(1'h1);
		// comparator crosses two flops plus the flag register
		idle(5);
		chk("low flag", 20'(low_flag), 20'h1);
		chk("low seg", 20'(disp.supply_monitor_input_seg), 20'h1);
		apk_host_i.drive_supply(1'h0);
		idle(5);
		chk("flag gone", 20'(low_flag), 20'h0);
		chk("seg gone", 20'(disp.supply_monitor_input_seg), 20'h0);
	endtask : t_supply
	task automatic t_midreset;
		apk_ctrl_t c = '0;
		apk_host_i.conv(20'h45670);
		c.peak_en = 1'h1;
		apk_host_i.set_ctrl(c);
		apk_host_i.pulse_trig;
		chk("pk before", 20'(peak), 20'h04567);
		sys_rst = 1'h1;
		idle(2);
		sys_rst = 1'h0;
		idle(1);
		chk("rst hi", 20'(res_hi), 20'h0);
		chk("rst lo", 20'(res_lo), 20'h0);
		chk("rst peak", 20'(peak), 20'h0);
		chk("rst busy", 20'(cal_busy), 20'h0);
		apk_host_i.set_ctrl('0);
		idle(2);
	endtask : t_midreset

	initial begin
		ref_clk = 1'h0;
		sys_rst = 1'h1;
		miscompares = 0;
		checks_done = 0;
		repeat (5) @(negedge ref_clk);
		sys_rst = 1'h0;
		idle(1);
		t_reset;
		t_result;
		t_negative;
		t_peak;
		t_hold;
		t_power;
		t_cal;
		t_supply;
		t_midreset;
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
